// ==== hw/sasc_pkg.sv ====
// package for the converter sequencer control: constants, carriers, state type
// assumes a single 25 MHz clock and a synchronous active-high reset
// Contract
// - ten channels: nine pins plus internal reference
// - 12-bit result placed right or left aligned
// - window compares raw value before alignment
// - outside limits sets window_flag, irq if enabled
// - window active only when window_enable set
// - single-channel window checks selected channel only
// - first on wakes, later on after settle starts
// - clearing on stops and powers down, reports done
// - reset state is power-down
// - up to five slots, any channel order
// - slot channel 4 bits, length 3 bits
// - single mode converts once then stops
// - each result stored per slot, sets done flag
// - continuous mode repeats until stopped
// - scan steps slots in order
// - continuous scan restarts at first slot
// - each slot owns its result register
// - end flag set sample_cycles plus 12 conversion cycles after start, plus 2 in single mode or first of a continuous run
// - one shared sample_cycles for all channels
// - conversion clock divided HSI, timebase 1 MHz
// - time is sample plus 12, plus 2 in single mode or first of a continuous run
// - rising edge of selected trigger starts conversion
package sasc_pkg;
   localparam int SASC_CHANNELS = 10;
   localparam int SASC_SLOTS = 5;
   localparam logic [3:0] SASC_INTERNAL_CH = 4'h9;
   localparam logic [3:0] SASC_TRIG_SOFT = 4'h9;
   localparam logic [3:0] SASC_TRIG_LAST = 4'h9;
   localparam int SASC_CLK_HZ = 25000000;
   localparam int SASC_SETTLE_NS = 1000;
   localparam int SASC_SETTLE_CYC =
      (SASC_SETTLE_NS * (SASC_CLK_HZ / 1000000) + 999) / 1000;
   localparam int SASC_PDOWN_CYC = 4;
   localparam logic [5:0] SASC_CONV_BASE = 6'h0C;
   localparam logic [5:0] SASC_FIRST_EXTRA = 6'h02;
   localparam logic [11:0] SASC_UPPER_RST = 12'hFFF;
   localparam logic [11:0] SASC_LOWER_RST = 12'h000;

   typedef struct packed {
      logic continuous_select;
      logic scan_enable;
      logic align_select;
      logic [2:0] sequence_length;
      logic [4:0] sample_cycles;
      logic ext_trigger_enable;
      logic [3:0] trigger_source_select;
   } sasc_cfg_t;

   typedef struct packed {
      logic window_enable;
      logic window_single_channel;
      logic [3:0] window_channel_select;
      logic [11:0] upper_limit;
      logic [11:0] lower_limit;
   } sasc_win_t;

   typedef enum logic [2:0] {
      SASC_OFF = 3'b000,
      SASC_SETTLE = 3'b001,
      SASC_READY = 3'b011,
      SASC_CONV = 3'b010,
      SASC_PDOWN = 3'b110
   } sasc_state_t;
endpackage : sasc_pkg

// ==== hw/sasc_sync.sv ====
// three-stage synchroniser with agreement of the last two stages
// assumes input is asynchronous to clk
`timescale 1ns/10ps
module sasc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   genvar i;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               q[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
               q[i] <= s3_r[i];
            end
         end
      end
   endgenerate
endmodule : sasc_sync

// ==== hw/sasc_ctrl.sv ====
// sequencer control: power switching, slot sequencing, timing, window, results
// assumes analog core holds its raw 12-bit value on raw_value in the last conversion cycle
// one clk cycle stands for one conversion clock cycle
`timescale 1ns/10ps
module sasc_ctrl #(
   parameter int SETTLE_CYC = sasc_pkg::SASC_SETTLE_CYC,
   parameter int PDOWN_CYC = sasc_pkg::SASC_PDOWN_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic on_wr,
   input wire logic on_value,
   input wire sasc_pkg::sasc_cfg_t cfg,
   input wire sasc_pkg::sasc_win_t win,
   input wire logic [19:0] slot_channels,
   input wire logic conversion_done_irq_en,
   input wire logic window_irq_en,
   input wire logic conversion_done_clr,
   input wire logic window_flag_clr,
   input wire logic [8:0] trig_events,
   input wire logic soft_trigger,
   input wire logic [11:0] raw_value,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic ref_enable,
   output logic analog_power,
   output logic powerup_done,
   output logic powerdown_done,
   output logic busy,
   output logic [79:0] result_value,
   output logic conversion_done_flag,
   output logic window_flag,
   output logic irq
);
   import sasc_pkg::*;

   // the shared 16-bit timer bounds both counts
   if (SETTLE_CYC < 1 || PDOWN_CYC < 1 ||
       SETTLE_CYC > 65536 || PDOWN_CYC > 65536) begin : g_bad_cnt
      $error("settle and power-down counts must lie between 1 and 65536");
   end

   sasc_state_t state_r;
   logic [15:0] timer_r;
   logic [5:0] cyc_r;
   logic [5:0] conv_len;
   logic [2:0] slot_r;
   logic first_r;
   logic [8:0] trig_sync;
   logic done_nxt;
   logic win_nxt;
   logic trig_prev_r;
   logic trig_sel;
   logic trig_rise;
   logic start_req;
   logic conv_end;
   logic last_slot;
   logic [2:0] len_eff;
   logic win_hit;
   logic [15:0] aligned;
   logic [3:0] cur_ch;

   sasc_sync #(.WIDTH(9)) u_trig_sync (
      .clk(clk),
      .rst(rst),
      .d(trig_events),
      .q(trig_sync)
   );

   always_comb begin
      if (cfg.trigger_source_select == SASC_TRIG_SOFT) begin
         trig_sel = soft_trigger;
      end else if (cfg.trigger_source_select < SASC_TRIG_LAST) begin
         trig_sel = trig_sync[cfg.trigger_source_select];
      end else begin
         trig_sel = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_sel;
      end
   end

   assign trig_rise = cfg.ext_trigger_enable && trig_sel && !trig_prev_r;
   assign start_req = (on_wr && on_value) || trig_rise;

   // sequence length 0 treated as one slot, above five clamped
   assign len_eff = (cfg.sequence_length == 3'h0) ? 3'h1 :
                    (cfg.sequence_length > 3'h5) ? 3'h5 : cfg.sequence_length;
   assign last_slot = !cfg.scan_enable || (slot_r == len_eff - 3'h1);
   assign cur_ch = slot_channels[slot_r*4 +: 4];
   // single mode, or first of a continuous run, pays two extra cycles
   assign conv_len = {1'b0, cfg.sample_cycles} + SASC_CONV_BASE +
                     ((first_r || !cfg.continuous_select) ? SASC_FIRST_EXTRA : 6'h00);
   assign conv_end = (state_r == SASC_CONV) && (cyc_r == conv_len - 6'h1);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= SASC_OFF;
         timer_r <= '0;
      end else begin
         case (state_r)
            SASC_OFF: begin
               if (on_wr && on_value) begin
                  state_r <= SASC_SETTLE;
                  timer_r <= '0;
               end
            end
            // settle counted in clk cycles, standing in for the 1 MHz timebase
            SASC_SETTLE: begin
               if (on_wr && !on_value) begin
                  state_r <= SASC_PDOWN;
                  timer_r <= '0;
               end else if (timer_r == 16'(SETTLE_CYC - 1)) begin
                  state_r <= SASC_READY;
               end else begin
                  timer_r <= timer_r + 16'h1;
               end
            end
            SASC_READY: begin
               if (on_wr && !on_value) begin
                  state_r <= SASC_PDOWN;
                  timer_r <= '0;
               end else if (start_req) begin
                  state_r <= SASC_CONV;
               end
            end
            SASC_CONV: begin
               if (on_wr && !on_value) begin
                  state_r <= SASC_PDOWN;
                  timer_r <= '0;
               end else if (conv_end && last_slot && !cfg.continuous_select) begin
                  state_r <= SASC_READY;
               end
            end
            SASC_PDOWN: begin
               if (timer_r == 16'(PDOWN_CYC - 1)) begin
                  state_r <= SASC_OFF;
               end else begin
                  timer_r <= timer_r + 16'h1;
               end
            end
            default: begin
               state_r <= SASC_OFF;
               timer_r <= '0;
            end
         endcase
      end
   end

   // conversion cycle counter, slot pointer and first-conversion marker
   always_ff @(posedge clk) begin
      if (rst) begin
         cyc_r <= '0;
         slot_r <= '0;
         first_r <= 1'b1;
      end else if (state_r != SASC_CONV) begin
         cyc_r <= '0;
         slot_r <= '0;
         first_r <= 1'b1;
      end else if (conv_end) begin
         cyc_r <= '0;
         first_r <= 1'b0;
         slot_r <= last_slot ? 3'h0 : slot_r + 3'h1;
      end else begin
         cyc_r <= cyc_r + 6'h1;
      end
   end

   // raw compare, independent of alignment
   assign win_hit = win.window_enable &&
                    (!win.window_single_channel || win.window_channel_select == cur_ch) &&
                    (raw_value > win.upper_limit || raw_value < win.lower_limit);
   assign aligned = cfg.align_select ? {raw_value, 4'h0} : {4'h0, raw_value};

   genvar s;
   generate
      for (s = 0; s < SASC_SLOTS; s++) begin : g_slot
         always_ff @(posedge clk) begin
            if (rst) begin
               result_value[s*16 +: 16] <= '0;
            end else if (conv_end && slot_r == 3'(s)) begin
               result_value[s*16 +: 16] <= aligned;
            end
         end
      end
   endgenerate

   // set wins over a clear in the same cycle
   always_comb begin
      done_nxt = conversion_done_flag;
      win_nxt = window_flag;
      if (conv_end) begin
         done_nxt = 1'b1;
      end else if (conversion_done_clr) begin
         done_nxt = 1'b0;
      end
      if (conv_end && win_hit) begin
         win_nxt = 1'b1;
      end else if (window_flag_clr) begin
         win_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         conversion_done_flag <= 1'b0;
         window_flag <= 1'b0;
      end else begin
         conversion_done_flag <= done_nxt;
         window_flag <= win_nxt;
      end
   end

   // built from next flag values, so irq never outlives a cleared flag
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (conversion_done_irq_en && done_nxt) ||
                (window_irq_en && win_nxt);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         conv_start <= 1'b0;
         conv_channel <= '0;
         ref_enable <= 1'b0;
         analog_power <= 1'b0;
         powerup_done <= 1'b0;
         powerdown_done <= 1'b1;
         busy <= 1'b0;
      end else begin
         conv_start <= (state_r == SASC_CONV) && (cyc_r == 6'h0) && !conv_end;
         conv_channel <= cur_ch;
         ref_enable <= (state_r == SASC_CONV) && (cur_ch == SASC_INTERNAL_CH);
         analog_power <= (state_r == SASC_SETTLE) || (state_r == SASC_READY) ||
                         (state_r == SASC_CONV);
         powerup_done <= (state_r == SASC_READY) || (state_r == SASC_CONV);
         powerdown_done <= (state_r == SASC_OFF);
         busy <= (state_r == SASC_CONV);
      end
   end
endmodule : sasc_ctrl

// ==== dv/sasc_ctrl_checker.sv ====
// port checker for the sequencer control
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module sasc_ctrl_checker (
   input wire logic clk,
   input wire logic rst,
   input wire sasc_pkg::sasc_win_t win,
   input wire logic conversion_done_clr,
   input wire logic window_flag_clr,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic ref_enable,
   input wire logic analog_power,
   input wire logic powerup_done,
   input wire logic powerdown_done,
   input wire logic busy,
   input wire logic conversion_done_flag,
   input wire logic window_flag,
   input wire logic irq
);
   import sasc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // shortest conversion is twelve cycles, so eight is a safe floor
   sequence s_quiet;
      !conv_start [*8];
   endsequence
   chk_done_sticky: assert property (
      conversion_done_flag && !conversion_done_clr |=> conversion_done_flag)
      else $error("done flag dropped");
   chk_win_sticky: assert property (
      window_flag && !window_flag_clr |=> window_flag) else $error("window flag dropped");
   chk_irq_cause: assert property (
      $rose(irq) |-> conversion_done_flag || window_flag) else $error("irq without flag");
   chk_win_gate: assert property (
      $rose(window_flag) |-> $past(win.window_enable))
      else $error("window flag while disabled");
   chk_conv_span: assert property (
      conv_start |=> s_quiet) else $error("conversion too short");
   chk_ref_chan: assert property (
      ref_enable |-> conv_channel == SASC_INTERNAL_CH) else $error("reference on wrong channel");
   chk_start_ready: assert property (
      conv_start |-> powerup_done && analog_power && busy) else $error("start while unpowered");
   chk_reset_off: assert property (disable iff (1'b0)
      rst |=> powerdown_done && !powerup_done && !busy) else $error("reset not powered down");
   chk_pdown_unpow: assert property (
      powerdown_done |-> !analog_power && !busy) else $error("powered while down");
   chk_flag_busy: assert property (
      $rose(conversion_done_flag) |-> $past(busy)) else $error("flag outside conversion");
endmodule : sasc_ctrl_checker

bind sasc_ctrl sasc_ctrl_checker sasc_ctrl_checker_i (.clk, .rst, .win, .conversion_done_clr,
   .window_flag_clr, .conv_start, .conv_channel, .ref_enable, .analog_power, .powerup_done,
   .powerdown_done, .busy, .conversion_done_flag, .window_flag, .irq);

// ==== dv/sasc_analog_model.sv ====
// analog core stand-in: a fixed value per channel while converting
// assumes busy frames each conversion
`timescale 1ns/10ps
module sasc_analog_model (
   input wire logic clk,
   input wire logic busy,
   input wire logic [3:0] conv_channel,
   output logic [11:0] raw_value
);
   logic [11:0] churn_r = 12'h000;
   // idle output keeps moving so a stale sample never looks right
   always_ff @(posedge clk) churn_r <= churn_r + 12'h3A7;
   always_comb raw_value = !busy ? churn_r : (conv_channel == 4'h9) ? 12'h5D0 :
      {conv_channel, conv_channel ^ 4'hA, 4'h3};
endmodule : sasc_analog_model

// ==== dv/sasc_ctrl_bench.sv ====
// self-checking bench for the sequencer control
// assumes settle and power-down counts shortened to 3 and 2
`timescale 1ns/10ps
module sasc_ctrl_bench;
   import sasc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, on_wr = 1'b0, on_value = 1'b0, soft_trigger = 1'b0;
   logic conversion_done_irq_en = 1'b0, window_irq_en = 1'b0;
   logic conversion_done_clr = 1'b0, window_flag_clr = 1'b0;
   sasc_cfg_t cfg = '0;
   sasc_win_t win = '0;
   logic [19:0] slot_channels = 20'h00000;
   logic [8:0] trig_events = 9'h000;
   logic [11:0] raw_value;
   logic conv_start, ref_enable, analog_power, powerup_done, powerdown_done, busy;
   logic conversion_done_flag, window_flag, irq;
   logic [3:0] conv_channel;
   logic [79:0] result_value;
   logic [2:0] lens [4] = '{3'h5, 3'h1, 3'h0, 3'h7};
   int failures = 0, checks_done = 0, n, ln;
   localparam int SETTLE = 3;
   localparam int PDOWN = 2;
   // conversion length beyond sample_cycles: steady, and single or first of a run
   localparam int CONV_RUN = int'(SASC_CONV_BASE);
   localparam int CONV_ONE = CONV_RUN + int'(SASC_FIRST_EXTRA);
   always #20 clk = ~clk;
   sasc_ctrl #(.SETTLE_CYC(SETTLE), .PDOWN_CYC(PDOWN)) sasc_ctrl_i (.clk, .rst, .on_wr, .on_value,
      .cfg,
      .win, .slot_channels, .conversion_done_irq_en, .window_irq_en, .conversion_done_clr,
      .window_flag_clr, .trig_events, .soft_trigger, .raw_value, .conv_start, .conv_channel,
      .ref_enable, .analog_power, .powerup_done, .powerdown_done, .busy, .result_value,
      .conversion_done_flag, .window_flag, .irq);
   sasc_analog_model sasc_analog_model_i (.clk, .busy, .conv_channel, .raw_value);
   task automatic end_sim;
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic cmp(input string what, input logic [79:0] exp, input logic [79:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wt(input int sel, input logic lvl, input int lim);
      logic s;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         s = sel == 0 ? busy : sel == 1 ? powerup_done : sel == 2 ? powerdown_done :
            conversion_done_flag;
      end while (s !== lvl && n < lim);
      if (s !== lvl) begin
         cmp("wait", lvl, s);
         end_sim();
      end
   endtask : wt
   task automatic pw(input logic v);
      @(posedge clk);
      on_wr <= 1'b1;
      on_value <= v;
      @(posedge clk);
      on_wr <= 1'b0;
   endtask : pw
   task automatic clr;
      @(posedge clk);
      {conversion_done_clr, window_flag_clr} <= 2'h3;
      @(posedge clk);
      {conversion_done_clr, window_flag_clr} <= 2'h0;
   endtask : clr
   // code 10 means a start by the on bit, others pick a trigger source
   task automatic go(input int c);
      if (c == 10) pw(1'b1);
      else begin
         @(posedge clk);
         if (c == 9) soft_trigger <= 1'b1;
         else trig_events[c] <= 1'b1;
         @(posedge clk);
         // soft bit is same-clock, pin sources must outlast the synchroniser
         soft_trigger <= 1'b0;
         if (c != 9) repeat (3) @(posedge clk);
         trig_events <= 9'h000;
      end
      wt(0, 1'b1, 12);
      cmp("conv_channel", slot_channels[3:0], conv_channel);
      cmp("ref_enable", slot_channels[3:0] == 4'h9, ref_enable);
      wt(0, 1'b0, 900);
   endtask : go
   task automatic check_run(input int len);
      logic [11:0] v;
      logic [3:0] ch;
      logic wf;
      wf = 1'b0;
      for (int k = 0; k < len; k++) begin
         ch = slot_channels[4*k +: 4];
         v = (ch == 4'h9) ? 12'h5D0 : {ch, ch ^ 4'hA, 4'h3};
         if (win.window_enable && (!win.window_single_channel || ch == win.window_channel_select)
            && (v > win.upper_limit || v < win.lower_limit)) wf = 1'b1;
         cmp("result", cfg.align_select ? {v, 4'h0} : {4'h0, v}, result_value[16*k +: 16]);
      end
      cmp("done flag", 1, conversion_done_flag);
      cmp("window flag", wf, window_flag);
      cmp("irq", conversion_done_irq_en | (wf & window_irq_en), irq);
      clr();
   endtask : check_run
   initial begin
      void'($urandom(94));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      cmp("powerdown_done", 1, powerdown_done);
      pw(1'b1);
      wt(1, 1'b1, 50);
      // one edge more for the registered ready flag
      cmp("settle", SETTLE + 1, n);
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 5; k++) slot_channels[4*k +: 4] <= 4'($urandom_range(9));
         cfg.scan_enable <= 1'b1;
         cfg.align_select <= r[0];
         cfg.sequence_length <= lens[r];
         cfg.sample_cycles <= 5'($urandom);
         win <= 30'($urandom);
         {conversion_done_irq_en, window_irq_en} <= 2'($urandom);
         go(10);
         ln = lens[r] == 3'h0 ? 1 : lens[r] > 3'h5 ? 5 : int'(lens[r]);
         cmp("conv cycles", ln * (CONV_ONE + int'(cfg.sample_cycles)), n);
         check_run(ln);
      end
      cfg.ext_trigger_enable <= 1'b1;
      cfg.scan_enable <= 1'b0;
      for (int c = 0; c < 10; c++) begin
         cfg.trigger_source_select <= 4'(c);
         slot_channels[3:0] <= 4'(c);
         go(c);
         cmp("conv cycles", CONV_ONE + int'(cfg.sample_cycles), n);
         check_run(1);
      end
      // codes above the last source must never start a conversion
      cfg.trigger_source_select <= 4'hA + 4'($urandom_range(5));
      @(posedge clk);
      soft_trigger <= 1'b1;
      trig_events <= 9'h1FF;
      repeat (8) @(posedge clk);
      soft_trigger <= 1'b0;
      trig_events <= 9'h000;
      #1;
      cmp("refused start", 0, busy);
      cfg.ext_trigger_enable <= 1'b0;
      cfg.continuous_select <= 1'b1;
      cfg.scan_enable <= 1'b1;
      cfg.sequence_length <= 3'h2;
      win.window_enable <= 1'b0;
      pw(1'b1);
      wt(3, 1'b1, 300);
      cmp("first conv", CONV_ONE + int'(cfg.sample_cycles), n);
      clr();
      wt(3, 1'b1, 300);
      // the clear pulse spends two of the edges counted here
      cmp("later conv", CONV_RUN - 2 + int'(cfg.sample_cycles), n);
      clr();
      wt(3, 1'b1, 300);
      cmp("busy", 1, busy);
      pw(1'b0);
      wt(2, 1'b1, 100);
      cmp("analog_power", 0, analog_power);
      check_run(2);
      end_sim();
   end
endmodule : sasc_ctrl_bench
